// [verilog/sirq_regs.vh]
// Register offsets, field positions and reset values of the sensor control bank.
`ifndef SIRQ_REGS_VH
`define SIRQ_REGS_VH

// Register offsets on the management port.
`define SIRQ_ADDR_GAIN_CEIL   8'hf4
`define SIRQ_ADDR_IRQ_EN      8'hf5
`define SIRQ_ADDR_ACTION      8'hf6
`define SIRQ_ADDR_POFS_LO     8'hf7
`define SIRQ_ADDR_POFS_HI     8'hf8
`define SIRQ_ADDR_MASK_LIGHT  8'hf9
`define SIRQ_ADDR_MASK_OTHER  8'hfa

// Reset values.
`define SIRQ_RST_GAIN_CEIL    3'h6
`define SIRQ_RST_IRQ_EN       8'h00
`define SIRQ_RST_ACTION       3'h0
`define SIRQ_RST_POFS         8'h00
`define SIRQ_RST_MASK_LIGHT   8'h00
`define SIRQ_RST_MASK_OTHER   5'h00
`define SIRQ_RST_COUNT        7'h00

// Field widths of the narrow registers.
`define SIRQ_GAIN_W           3
`define SIRQ_ACTION_W         3
`define SIRQ_MASK_OTHER_W     5

// Byte lanes of the proximity offset.
`define SIRQ_POFS_LO          7:0
`define SIRQ_POFS_HI          15:8

// Action control bit positions.
`define SIRQ_ACT_WAKE         0
`define SIRQ_ACT_FLUSH        1
`define SIRQ_ACT_AUTOZERO     2

// Interrupt enable bit positions.
`define SIRQ_IEN_SYSTEM       0
`define SIRQ_IEN_CALIB        1
`define SIRQ_IEN_BUFFER       2
`define SIRQ_IEN_LIGHT_THR    3
`define SIRQ_IEN_PROX_THR     4
`define SIRQ_IEN_PROX_SAT     5
`define SIRQ_IEN_FLICK_SAT    6
`define SIRQ_IEN_LIGHT_SAT    7

// Second source mask bit positions.
`define SIRQ_MAP_PROX_A       0
`define SIRQ_MAP_PROX_B       1
`define SIRQ_MAP_PROX_RATIO   2
`define SIRQ_MAP_FLICK_DATA   3
`define SIRQ_MAP_FLICK_RES    4

// Buffer push vector layout: eight light channels, then five others.
`define SIRQ_PUSH_OTHER_BASE  8
`define SIRQ_PUSH_W           13

// Buffer entry capacity: 256 bytes of four-byte entries.
`define SIRQ_BUF_ENTRIES      7'h40
`define SIRQ_COUNT_W          7
`define SIRQ_COUNT_ONE        7'h01

// Zero byte for unmapped reads and reserved bits.
`define SIRQ_ZERO_BYTE        8'h00

`endif

// [verilog/sirq_irq_gate.v]
// Per-source interrupt enable gating with registered outputs.
`timescale 1ns/1ps
module sirq_irq_gate #(
	parameter N = 8
) (
	// Clock and reset.
	input  wire         clk,
	input  wire         resetn,
	// Raw events and their enables.
	input  wire [N-1:0] irq_source_raw,
	input  wire [N-1:0] irq_enable,
	// Gated events and combined request.
	output reg  [N-1:0] irq_events,
	output reg          irq_request
);

	genvar i;

	// Each source passes only while its enable bit is set.
	generate
		for (i = 0; i < N; i = i + 1) begin : g_src
			always @(posedge clk) begin
				if (!resetn) begin
					irq_events[i] <= 1'b0;
				end else begin
					irq_events[i] <= irq_source_raw[i] & irq_enable[i];
				end
			end
		end
	endgenerate

	// Any enabled source raises the combined request.
	always @(posedge clk) begin
		if (!resetn) begin
			irq_request <= 1'b0;
		end else begin
			irq_request <= |(irq_source_raw & irq_enable);
		end
	end

endmodule // sirq_irq_gate

// [verilog/sirq_buf_select.v]
// Chooses which finished measurement results are pushed into the buffer.
`timescale 1ns/1ps
module sirq_buf_select #(
	parameter N = 13
) (
	// Clock and reset.
	input  wire         clk,
	input  wire         resetn,
	// Result strobes per source and the source masks.
	input  wire [N-1:0] result_valid,
	input  wire [N-1:0] source_mask,
	// Push requests toward the buffer writer.
	output reg  [N-1:0] buffer_push
);

	genvar i;

	// A result is pushed only when its source is selected.
	generate
		for (i = 0; i < N; i = i + 1) begin : g_push
			always @(posedge clk) begin
				if (!resetn) begin
					buffer_push[i] <= 1'b0;
				end else begin
					buffer_push[i] <= result_valid[i] & source_mask[i];
				end
			end
		end
	endgenerate

endmodule // sirq_buf_select

// [verilog/sirq_ctrl_regs.v]
// Configuration and action registers of the light and proximity sensor.
//
// Function
// - Three-bit modulator gain ceiling, read/write, resets to binary 110.
// - Enable bit 7 lets light saturation events raise an interrupt.
// - Enable bit 6 lets flicker saturation events raise an interrupt.
// - Enable bit 5 lets proximity saturation events raise an interrupt.
// - Enable bit 4 lets filtered proximity threshold events interrupt.
// - Enable bit 3 gates light threshold interrupts and is mirrored out.
// - Enable bit 2 lets buffer level threshold events interrupt.
// - Enable bit 1 lets calibration complete events interrupt.
// - Enable bit 0 lets flicker status change system events interrupt.
// - Control bit 2 starts light autozero only while the light engine is off.
// - Control bit 1 flushes buffer, clearing level and buffer flag; overflow clears unless a push is lost in the flush cycle.
// - Control bit 0 clears sleep indicator and resumes measurement, unless an interrupt with sleep enabled arrives in the same cycle.
// - Sixteen-bit proximity offset at 0xf7 low and 0xf8 high, reset zero.
// - Light mask bit n pushes light channel n result into the buffer.
// - Other mask bit 4 pushes the flicker calculation result.
// - Other mask bit 3 pushes raw flicker samples.
// - Other mask bits 2..0 push proximity ratio, result one, result zero.
// - Sleep indicator reads one after interrupt sleep until cleared.
// - Fill count reports unread four-byte entries, zero to sixty-four.
// - Overflow flag sets when data is lost, clears when buffer is read.
`timescale 1ns/1ps
`include "sirq_regs.vh"
module sirq_ctrl_regs (
	// Clock and reset.
	input  wire        clk,
	input  wire        resetn,
	// Register port from the serial management front end.
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_write,
	input  wire        reg_read,
	output reg  [7:0]  reg_rdata,
	// Measurement engine configuration and actions.
	input  wire        light_engine_en,
	output reg  [2:0]  modulator_gain_ceiling,
	output reg  [15:0] prox_offset_b,
	output reg         light_manual_autozero,
	output reg         wake_from_irq_sleep,
	output reg         measurement_active,
	// Interrupt sources, enables and gated events.
	input  wire [7:0]  irq_source_raw,
	input  wire        irq_sleep_enable,
	output reg         light_threshold_irq_en,
	output wire [7:0]  irq_events,
	output wire        irq_request,
	output reg         irq_sleep_indicator,
	// Result strobes that may feed the buffer.
	input  wire [7:0]  light_result_valid,
	input  wire        flicker_result_valid,
	input  wire        flicker_sample_valid,
	input  wire        prox_ratio_valid,
	input  wire        prox_b_valid,
	input  wire        prox_a_valid,
	output wire [12:0] buffer_push,
	// Buffer level bookkeeping.
	input  wire        buffer_entry_write,
	input  wire        buffer_entry_read,
	input  wire [6:0]  buffer_threshold,
	output reg         buffer_flush,
	output reg  [6:0]  buffer_fill_count,
	output reg         buffer_overflow_flag,
	output reg         buffer_irq_flag
);

	// Stored configuration.
	reg  [7:0]                     irq_enable;
	reg  [7:0]                     mask_light;
	reg  [`SIRQ_MASK_OTHER_W-1:0]  mask_other;
	reg  [`SIRQ_ACTION_W-1:0]      action_pending;

	// Decoded accesses.
	wire wr_gain;
	wire wr_irq;
	wire wr_act;
	wire wr_pofs_lo;
	wire wr_pofs_hi;
	wire wr_mask_l;
	wire wr_mask_o;

	// Next values.
	reg  [7:0]               next_rdata;
	reg  [`SIRQ_COUNT_W-1:0] next_count;
	reg                      next_overflow;
	reg                      next_sleep;

	// Buffer bookkeeping terms.
	wire                     do_flush;
	wire                     buf_full;
	wire                     pop_ok;
	wire                     push_ok;
	wire                     push_lost;

	// Combined result strobes and masks for the selector.
	wire [`SIRQ_PUSH_W-1:0]  result_valid;
	wire [`SIRQ_PUSH_W-1:0]  source_mask;

	// Address decode of the write strobes.
	assign wr_gain    = reg_write && (reg_addr == `SIRQ_ADDR_GAIN_CEIL);
	assign wr_irq     = reg_write && (reg_addr == `SIRQ_ADDR_IRQ_EN);
	assign wr_act     = reg_write && (reg_addr == `SIRQ_ADDR_ACTION);
	assign wr_pofs_lo = reg_write && (reg_addr == `SIRQ_ADDR_POFS_LO);
	assign wr_pofs_hi = reg_write && (reg_addr == `SIRQ_ADDR_POFS_HI);
	assign wr_mask_l  = reg_write && (reg_addr == `SIRQ_ADDR_MASK_LIGHT);
	assign wr_mask_o  = reg_write && (reg_addr == `SIRQ_ADDR_MASK_OTHER);

	// Gain ceiling keeps only its three field bits.
	// Upper bits of the written byte are reserved and simply dropped.
	always @(posedge clk) begin
		if (!resetn) begin
			modulator_gain_ceiling <= `SIRQ_RST_GAIN_CEIL;
		end else if (wr_gain) begin
			modulator_gain_ceiling <= reg_wdata[`SIRQ_GAIN_W-1:0];
		end
	end

	// Interrupt enable byte, one bit per source.
	// Bit positions follow the order of the raw source vector.
	always @(posedge clk) begin
		if (!resetn) begin
			irq_enable <= `SIRQ_RST_IRQ_EN;
		end else if (wr_irq) begin
			irq_enable <= reg_wdata;
		end
	end

	// The light threshold enable is copied out for the main enable register.
	always @(posedge clk) begin
		if (!resetn) begin
			light_threshold_irq_en <= 1'b0;
		end else if (wr_irq) begin
			light_threshold_irq_en <= reg_wdata[`SIRQ_IEN_LIGHT_THR];
		end
	end

	// Proximity offset, written one byte at a time.
	// The halves are independent, so an engine that samples between the
	// low and the high write sees a mixed value for one measurement.
	always @(posedge clk) begin
		if (!resetn) begin
			prox_offset_b <= {`SIRQ_RST_POFS, `SIRQ_RST_POFS};
		end else begin
			if (wr_pofs_lo) begin
				prox_offset_b[`SIRQ_POFS_LO] <= reg_wdata;
			end
			if (wr_pofs_hi) begin
				prox_offset_b[`SIRQ_POFS_HI] <= reg_wdata;
			end
		end
	end

	// Buffer source masks.
	// Reserved upper bits of the second mask are not stored at all.
	always @(posedge clk) begin
		if (!resetn) begin
			mask_light <= `SIRQ_RST_MASK_LIGHT;
			mask_other <= `SIRQ_RST_MASK_OTHER;
		end else begin
			if (wr_mask_l) begin
				mask_light <= reg_wdata;
			end
			if (wr_mask_o) begin
				mask_other <= reg_wdata[`SIRQ_MASK_OTHER_W-1:0];
			end
		end
	end

	// Action bits stay set for one cycle and are then dropped.
	// Dropping them at once lets a second write of one repeat the action,
	// and a read just after the write still shows what was requested.
	always @(posedge clk) begin
		if (!resetn) begin
			action_pending <= `SIRQ_RST_ACTION;
		end else if (wr_act) begin
			action_pending <= reg_wdata[`SIRQ_ACTION_W-1:0];
		end else begin
			action_pending <= `SIRQ_RST_ACTION;
		end
	end

	// Autozero is refused while the light engine still runs.
	// Starting it mid-measurement would spoil the running conversion.
	always @(posedge clk) begin
		if (!resetn) begin
			light_manual_autozero <= 1'b0;
		end else begin
			light_manual_autozero <= action_pending[`SIRQ_ACT_AUTOZERO] &
				~light_engine_en;
		end
	end

	// Flush and wake pulses follow their pending bits.
	always @(posedge clk) begin
		if (!resetn) begin
			buffer_flush        <= 1'b0;
			wake_from_irq_sleep <= 1'b0;
		end else begin
			buffer_flush        <= do_flush;
			wake_from_irq_sleep <= action_pending[`SIRQ_ACT_WAKE];
		end
	end

	// Sleep after interrupt: an interrupt arriving with the wake wins.
	// Letting the set win keeps a late interrupt from being lost.
	always @* begin
		next_sleep = irq_sleep_indicator;
		if (action_pending[`SIRQ_ACT_WAKE]) begin
			next_sleep = 1'b0;
		end
		if (irq_request && irq_sleep_enable) begin
			next_sleep = 1'b1;
		end
	end

	// Sleep indicator and the resulting run state.
	always @(posedge clk) begin
		if (!resetn) begin
			irq_sleep_indicator <= 1'b0;
			measurement_active  <= 1'b1;
		end else begin
			irq_sleep_indicator <= next_sleep;
			measurement_active  <= ~next_sleep;
		end
	end

	// Buffer level terms; a read of an empty buffer leaves the level unchanged.
	// A push into a full buffer is lost only when no entry leaves too.
	assign do_flush  = action_pending[`SIRQ_ACT_FLUSH];
	assign buf_full  = (buffer_fill_count == `SIRQ_BUF_ENTRIES);
	assign pop_ok    = buffer_entry_read && (buffer_fill_count != `SIRQ_RST_COUNT);
	assign push_ok   = buffer_entry_write && (!buf_full || pop_ok);
	assign push_lost = buffer_entry_write && buf_full && !pop_ok;

	// Next fill count and overflow flag.
	// Flush wins over push and pop; a loss in the flush cycle still flags.
	always @* begin
		next_count    = buffer_fill_count;
		next_overflow = buffer_overflow_flag;
		if (do_flush) begin
			next_count = `SIRQ_RST_COUNT;
		end else if (push_ok && !pop_ok) begin
			next_count = buffer_fill_count + `SIRQ_COUNT_ONE;
		end else if (pop_ok && !push_ok) begin
			next_count = buffer_fill_count - `SIRQ_COUNT_ONE;
		end
		if (do_flush || buffer_entry_read) begin
			next_overflow = 1'b0;
		end
		if (push_lost) begin
			next_overflow = 1'b1;
		end
	end

	// Buffer level, overflow and threshold flag registers.
	// The level flag follows the next count so it never lags the level.
	always @(posedge clk) begin
		if (!resetn) begin
			buffer_fill_count    <= `SIRQ_RST_COUNT;
			buffer_overflow_flag <= 1'b0;
			buffer_irq_flag      <= 1'b0;
		end else begin
			buffer_fill_count    <= next_count;
			buffer_overflow_flag <= next_overflow;
			buffer_irq_flag      <= (next_count > buffer_threshold);
		end
	end

	// Read multiplexer; reserved bits and unmapped offsets read zero.
	always @* begin
		next_rdata = `SIRQ_ZERO_BYTE;
		case (reg_addr)
			`SIRQ_ADDR_GAIN_CEIL: begin
				next_rdata[`SIRQ_GAIN_W-1:0] = modulator_gain_ceiling;
			end
			`SIRQ_ADDR_IRQ_EN: begin
				next_rdata = irq_enable;
			end
			`SIRQ_ADDR_ACTION: begin
				next_rdata[`SIRQ_ACTION_W-1:0] = action_pending;
			end
			`SIRQ_ADDR_POFS_LO: begin
				next_rdata = prox_offset_b[`SIRQ_POFS_LO];
			end
			`SIRQ_ADDR_POFS_HI: begin
				next_rdata = prox_offset_b[`SIRQ_POFS_HI];
			end
			`SIRQ_ADDR_MASK_LIGHT: begin
				next_rdata = mask_light;
			end
			`SIRQ_ADDR_MASK_OTHER: begin
				next_rdata[`SIRQ_MASK_OTHER_W-1:0] = mask_other;
			end
			default: begin
				next_rdata = `SIRQ_ZERO_BYTE;
			end
		endcase
	end

	// Read data is captured on the read strobe and held otherwise.
	// Holding the byte lets the serial front end shift it out at leisure.
	always @(posedge clk) begin
		if (!resetn) begin
			reg_rdata <= `SIRQ_ZERO_BYTE;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end
	end

	// Interrupt sources gated by their enables, bit by bit.
	// The gate registers its outputs so every gated line leaves a flop.
	sirq_irq_gate #(
		.N (8)
	) u_irq_gate (
		.clk            (clk),
		.resetn         (resetn),
		.irq_source_raw (irq_source_raw),
		.irq_enable     (irq_enable),
		.irq_events     (irq_events),
		.irq_request    (irq_request)
	);

	// Results and masks laid out as light channels, then other sources.
	assign result_valid = {flicker_result_valid, flicker_sample_valid,
		prox_ratio_valid, prox_b_valid, prox_a_valid, light_result_valid};
	assign source_mask  = {mask_other, mask_light};

	// Buffer push selection.
	sirq_buf_select #(
		.N (`SIRQ_PUSH_W)
	) u_buf_select (
		.clk          (clk),
		.resetn       (resetn),
		.result_valid (result_valid),
		.source_mask  (source_mask),
		.buffer_push  (buffer_push)
	);

endmodule // sirq_ctrl_regs

// [bench/sirq_host_model.sv]
// Host model that reaches the register bank through its strobe port.
`timescale 1ns/1ps
module sirq_host_model (
	// Clock and returned data.
	input  wire       clk,
	input  wire [7:0] reg_rdata,
	// Request lines.
	output reg  [7:0] reg_addr,
	output reg  [7:0] reg_wdata,
	output reg        reg_write,
	output reg        reg_read
);
	// Idle state: both strobes low.
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end

	// One write; released lines are scrambled so stale values never help.
	task wr(input [7:0] a, input [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge clk);
		reg_write = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	// One read; the data loads on the read edge and is taken afterwards.
	task rd(input [7:0] a, output [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge clk);
		reg_read = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule // sirq_host_model

// [bench/sirq_ctrl_regs_chk.sv]
// Concurrent checks on the ports of the sensor control register bank.
`timescale 1ns/1ps
module sirq_ctrl_regs_chk (
	// Clock, reset and register port.
	input wire        clk,
	input wire        resetn,
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        reg_write,
	// Engine configuration and actions.
	input wire        light_engine_en,
	input wire [2:0]  modulator_gain_ceiling,
	input wire [15:0] prox_offset_b,
	input wire        light_manual_autozero,
	input wire        wake_from_irq_sleep,
	// Interrupts and sleep.
	input wire [7:0]  irq_source_raw,
	input wire        irq_sleep_enable,
	input wire [7:0]  irq_events,
	input wire        irq_request,
	input wire        irq_sleep_indicator,
	// Result strobes and buffer.
	input wire [7:0]  light_result_valid,
	input wire        flicker_result_valid,
	input wire        flicker_sample_valid,
	input wire        prox_ratio_valid,
	input wire        prox_b_valid,
	input wire        prox_a_valid,
	input wire [12:0] buffer_push,
	input wire        buffer_entry_write,
	input wire        buffer_entry_read,
	input wire        buffer_flush,
	input wire [6:0]  buffer_fill_count,
	input wire        buffer_overflow_flag
);
	reg  [7:0]  ien;
	reg  [7:0]  ml;
	reg  [4:0]  mo;
	wire [12:0] str;
	wire [12:0] msk;
	wire        act;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Shadow copies of the enable and mask registers.
	always @(posedge clk) begin
		if (!resetn) begin
			ien <= 8'h00;
			ml <= 8'h00;
			mo <= 5'h00;
		end else if (reg_write) begin
			case (reg_addr)
			8'hf5: ien <= reg_wdata;
			8'hf9: ml <= reg_wdata;
			8'hfa: mo <= reg_wdata[4:0];
			default: ;
			endcase
		end
	end

	// Strobes and masks in push vector order.
	assign str = {flicker_result_valid, flicker_sample_valid,
		prox_ratio_valid, prox_b_valid, prox_a_valid, light_result_valid};
	assign msk = {mo, ml};
	assign act = reg_write && reg_addr == 8'hf6;

	property p_gain;
		reg_write && reg_addr == 8'hf4 |=>
			{5'h00, modulator_gain_ceiling} == ($past(reg_wdata) & 8'h07);
	endproperty
	a_gain: assert property (p_gain)
		else $error("gain ceiling not loaded");
	property p_ofs;
		reg_write && reg_addr == 8'hf7 |=> prox_offset_b[7:0] == $past(reg_wdata);
	endproperty
	a_ofs: assert property (p_ofs)
		else $error("offset low byte not loaded");
	property p_ien;
		$past(resetn) |-> irq_events == ($past(irq_source_raw) & $past(ien))
			&& irq_request == |irq_events;
	endproperty
	a_ien: assert property (p_ien)
		else $error("interrupt gating wrong");
	property p_az;
		act && reg_wdata[2] ##1 !light_engine_en |=>
			light_manual_autozero ##1 !light_manual_autozero;
	endproperty
	a_az: assert property (p_az)
		else $error("autozero pulse wrong");
	property p_flush;
		act && reg_wdata[1] |-> ##2 buffer_flush && buffer_fill_count == 7'h00
			##1 !buffer_flush;
	endproperty
	a_flush: assert property (p_flush)
		else $error("flush wrong");
	property p_wake;
		act && reg_wdata[0] ##1 !(irq_request && irq_sleep_enable) |=>
			wake_from_irq_sleep && !irq_sleep_indicator;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake wrong");
	property p_sleep;
		irq_request && irq_sleep_enable |=> irq_sleep_indicator;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep indicator not set");
	property p_ovf;
		buffer_entry_write && !buffer_entry_read && buffer_fill_count == 7'h40
			&& !$past(act)
			|=> buffer_overflow_flag && buffer_fill_count == 7'h40;
	endproperty
	a_ovf: assert property (p_ovf)
		else $error("overflow handling wrong");
	property p_push;
		$past(resetn) |-> buffer_push == ($past(str) & $past(msk));
	endproperty
	a_push: assert property (p_push)
		else $error("buffer push wrong");
endmodule // sirq_ctrl_regs_chk

// [bench/sirq_tb.sv]
// Self-checking bench of the sensor control register bank.
`timescale 1ns/1ps
module tb;
	reg         clk;
	reg         resetn;
	reg         eng;
	reg  [7:0]  raw;
	reg         slp;
	reg  [12:0] strb;
	reg         ewr;
	reg         erd;
	reg  [6:0]  thr;
	wire [7:0]  addr;
	wire [7:0]  wdat;
	wire        wr;
	wire        rd;
	wire [7:0]  rdat;
	wire [2:0]  gain;
	wire [15:0] ofs;
	wire        az;
	wire        wake;
	wire        act;
	wire        mir;
	wire [7:0]  ev;
	wire        req;
	wire        sind;
	wire [12:0] push;
	wire        fl;
	wire [6:0]  cnt;
	wire        ovf;
	wire        bfl;
	integer     mismatches;
	integer     total_checks;
	integer     cyc;
	integer     n_az;
	integer     n_fl;
	integer     n_wk;

	sirq_host_model host (.clk(clk), .reg_rdata(rdat), .reg_addr(addr),
		.reg_wdata(wdat), .reg_write(wr), .reg_read(rd));

	sirq_ctrl_regs u_sirq_ctrl_regs (.clk(clk), .resetn(resetn),
		.reg_addr(addr), .reg_wdata(wdat), .reg_write(wr), .reg_read(rd),
		.reg_rdata(rdat), .light_engine_en(eng),
		.modulator_gain_ceiling(gain), .prox_offset_b(ofs),
		.light_manual_autozero(az), .wake_from_irq_sleep(wake),
		.measurement_active(act), .irq_source_raw(raw),
		.irq_sleep_enable(slp), .light_threshold_irq_en(mir),
		.irq_events(ev), .irq_request(req), .irq_sleep_indicator(sind),
		.light_result_valid(strb[7:0]), .flicker_result_valid(strb[12]),
		.flicker_sample_valid(strb[11]), .prox_ratio_valid(strb[10]),
		.prox_b_valid(strb[9]), .prox_a_valid(strb[8]), .buffer_push(push),
		.buffer_entry_write(ewr), .buffer_entry_read(erd),
		.buffer_threshold(thr), .buffer_flush(fl),
		.buffer_fill_count(cnt), .buffer_overflow_flag(ovf),
		.buffer_irq_flag(bfl));

	// Compares one value and reports a mismatch at once.
	task chk(input [15:0] got, input [15:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task test_done;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Reset values, read/write masks and an unmapped offset.
	task t_regs;
		reg [7:0] d;
		integer i;
		for (i = 0; i < 8; i = i + 1) begin
			host.rd(8'hf3 + i, d);
			chk(d, 64'h0000000000000600 >> (8 * i) & 8'hff);
			if (i != 3)
				host.wr(8'hf3 + i, 8'hff);
		end
		for (i = 0; i < 8; i = i + 1) begin
			host.rd(8'hf3 + i, d);
			chk(d, 64'h1fffffff00ff0700 >> (8 * i) & 8'hff);
		end
		chk(gain, 3'h7);
		chk(ofs, 16'hffff);
		chk(mir, 1'b1);
		for (i = 0; i < 8; i = i + 1)
			if (i != 3)
				host.wr(8'hf3 + i, 8'h00);
	endtask

	// Each enable alone passes only its own source.
	task t_irq;
		integer i;
		raw = 8'hff;
		for (i = 0; i < 9; i = i + 1) begin
			host.wr(8'hf5, 8'h01 << i);
			@(negedge clk);
			chk(ev, (8'h01 << i) & 8'hff);
			chk(req, i < 8);
			chk(mir, i == 3);
		end
		raw = 8'h00;
	endtask

	// Sleep after an interrupt, held until the wake action, then a second wake.
	task t_sleep;
		reg [7:0] d;
		host.wr(8'hf5, 8'h01);
		raw = 8'h01;
		slp = 1'b1;
		repeat (3) @(negedge clk);
		raw = 8'h00;
		slp = 1'b0;
		repeat (3) @(negedge clk);
		chk({sind, act}, 2'b10);
		host.wr(8'hf6, 8'h01);
		repeat (2) @(negedge clk);
		chk({sind, act}, 2'b01);
		host.wr(8'hf6, 8'h01);
		repeat (2) @(negedge clk);
		chk(n_wk, 2);
		host.rd(8'hf6, d);
		chk(d, 8'h00);
	endtask

	// Autozero is dropped while the engine runs.
	task t_az;
		eng = 1'b1;
		host.wr(8'hf6, 8'h04);
		repeat (3) @(negedge clk);
		chk(n_az, 0);
		eng = 1'b0;
		host.wr(8'hf6, 8'h04);
		repeat (3) @(negedge clk);
		chk(n_az, 1);
	endtask

	// Fill past capacity, read one, flush, then read while empty.
	task t_buf;
		ewr = 1'b1;
		repeat (65) @(negedge clk);
		ewr = 1'b0;
		@(negedge clk);
		chk({bfl, ovf, 7'h00, cnt}, 16'hc040);
		thr = 7'h40;
		@(negedge clk);
		chk(bfl, 1'b0);
		thr = 7'h03;
		erd = 1'b1;
		@(negedge clk);
		erd = 1'b0;
		@(negedge clk);
		chk({ovf, cnt}, 8'h3f);
		host.wr(8'hf6, 8'h02);
		repeat (2) @(negedge clk);
		chk({bfl, ovf, cnt}, 9'h000);
		chk(n_fl, 1);
		erd = 1'b1;
		@(negedge clk);
		erd = 1'b0;
		@(negedge clk);
		chk(cnt, 7'h00);
	endtask

	// Two mask patterns against all strobes at once.
	task t_push;
		host.wr(8'hf9, 8'ha5);
		host.wr(8'hfa, 8'h15);
		strb = 13'h1fff;
		@(negedge clk);
		strb = 13'h0000;
		chk(push, 13'h15a5);
		host.wr(8'hf9, 8'h5a);
		host.wr(8'hfa, 8'h0a);
		strb = 13'h1fff;
		@(negedge clk);
		strb = 13'h0000;
		chk(push, 13'h0a5a);
	endtask

	// Free-running clock.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Pulse counters and the hang limit.
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (resetn) begin
			n_az = n_az + az;
			n_fl = n_fl + fl;
			n_wk = n_wk + wake;
		end
		if (cyc == 3000) begin
			mismatches = mismatches + 1;
			test_done;
		end
	end

	// Main sequence.
	initial begin
		{resetn, eng, raw, slp, strb, ewr, erd} = 0;
		thr = 7'h03;
		{mismatches, total_checks, cyc, n_az, n_fl, n_wk} = 0;
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		t_regs;
		t_irq;
		t_sleep;
		t_az;
		t_buf;
		t_push;
		test_done;
	end
endmodule // tb

bind sirq_ctrl_regs sirq_ctrl_regs_chk u_chk (.*);
